// ---- design/rsm_pkg.sv ----
// Shared constants, types and register map of the radio sleep mode controller.
package rsm_pkg;

   // ==========================================================
   // Widths
   localparam int TIME_W = 16;
   localparam int ADDR_W = 5;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SLEEP_PERIOD = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_WAKE_TIME = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_TICK_DIV = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_OPER_SLEEP = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_OPER_WAKE = 5'h18;

   // ==========================================================
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FLOW_BIT = 4;
   localparam int CTRL_IND_BIT = 5;
   localparam int CTRL_PREF_BIT = 6;
   localparam int CTRL_W = 7;

   // ==========================================================
   // Status field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_SYNC_BIT = 4;
   localparam int STAT_COORD_BIT = 5;
   localparam int STAT_AWAKE_BIT = 6;
   localparam int STAT_NETWAKE_BIT = 7;

   // ==========================================================
   // Reset values and relay wait length in ticks
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [TIME_W-1:0] SLEEP_RST = 16'h0064;
   localparam logic [TIME_W-1:0] WAKE_RST = 16'h000a;
   localparam logic [TIME_W-1:0] TICK_DIV_RST = 16'h007c;
   localparam logic [TIME_W-1:0] RELAY_WAIT_TICKS = 16'h0004;

   // ==========================================================
   // Sleep mode select codes
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_PIN = 4'h1;
   localparam logic [3:0] MODE_CYC = 4'h4;
   localparam logic [3:0] MODE_CYC_PIN = 4'h5;
   localparam logic [3:0] MODE_SUPPORT = 4'h7;
   localparam logic [3:0] MODE_SYNC_CYC = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      ST_AWAKE = 4'b0001,
      ST_DRAIN = 4'b0010,
      ST_SLEEP = 4'b0100,
      ST_WAKE = 4'b1000
   } rsm_state_t;

   typedef struct packed {
      logic valid;
      logic [TIME_W-1:0] sleep_period;
      logic [TIME_W-1:0] wake_time;
   } rsm_sync_t;

endpackage

// ---- design/rsm_tick.sv ----
// Tick generator that divides the system clock for the sleep timers.
`timescale 1ns/1ps
`default_nettype none
module rsm_tick #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Divider and tick
   input wire logic [W-1:0] div,
   output logic tick
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_nxt;

   always_comb
   begin
      tick_nxt = 1'b0;
      cnt_nxt = cnt_r + 1'b1;
      if (cnt_r >= div)
      begin
         cnt_nxt = '0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= '0;
         tick <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick <= tick_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- design/rsm_countdown.sv ----
// Loadable countdown timer stepped by the tick.
`timescale 1ns/1ps
`default_nettype none
module rsm_countdown #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic tick,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // State
   output logic zero
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (load)
      begin
         cnt_nxt = load_val;
      end
      else if (tick && cnt_r != '0)
      begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign zero = (cnt_r == '0);
endmodule
`default_nettype wire

// ---- design/rsm_ctrl.sv ----
// Sleep mode controller top with its Avalon-MM register file.
//
// Summary of operation
// - Mode 0 never sleeps.
// - Mode 0 relays sync, never originates it.
// - Mode 0 forwards data at any time.
// - Mode 1 request high: finish activity, sleep.
// - Mode 1 request low wakes the device.
// - Mode 4 alternates sleep period and poll.
// - Arriving data postpones sleep, else sleep.
// - Cyclic sleep: indicator high awake, low asleep.
// - Flow control: CTS low awake, high draining or asleep.
// - Mode 5 wakes on expiry or request fall.
// - Mode 7 never sleeps, answers joiners anytime once synced.
// - Mode 7 sends data only in wake window once synced.
// - Mode 8 follows network, ignores input asleep.
// - Local timing only until synchronised.
// - Operating sleep and wake times readable.
// - Indicator enable gates mode 8 indicator.
// - Unsynced mode 8 listens, then sleeps.
// - Modes 4, 5: data starts countdown.
// - Further data restarts the countdown.
// - Countdown expiry re-enters sleep.
// - Coordinator sends one sync per wake; others relay.
// - Latest local timing change wins network-wide.
// - Unrelayed sync is resent exactly once.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rsm_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [rsm_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Host pins
   input wire logic sleep_request_input,
   input wire logic serial_rx_activity,
   // Radio side
   input wire logic rf_rx_activity,
   input wire logic radio_busy,
   input wire rsm_pkg::rsm_sync_t sync_in,
   input wire logic sync_join_req,
   input wire logic relay_heard,
   // Sleep outputs
   output logic awake_indicator,
   output logic cts_n,
   output logic radio_on,
   output logic serial_accept,
   output logic data_tx_allow,
   output rsm_pkg::rsm_sync_t sync_tx,
   output logic sync_relay
);
   localparam int TW = rsm_pkg::TIME_W;
   localparam int CW = rsm_pkg::CTRL_W;

   // ==========================================================
   // Declarations
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_nxt;
   logic [rsm_pkg::CTRL_W-1:0] ctrl_r;
   logic [rsm_pkg::CTRL_W-1:0] ctrl_nxt;
   logic [TW-1:0] sp_r;
   logic [TW-1:0] sp_nxt;
   logic [TW-1:0] wt_r;
   logic [TW-1:0] wt_nxt;
   logic [TW-1:0] div_r;
   logic [TW-1:0] div_nxt;
   logic wr_en;
   logic wr_time;
   logic mode_chg;
   rsm_pkg::rsm_state_t state_r;
   rsm_pkg::rsm_state_t state_nxt;
   logic synced_r;
   logic synced_nxt;
   logic coord_r;
   logic coord_nxt;
   logic net_wake_r;
   logic net_wake_nxt;
   logic [TW-1:0] op_sleep_r;
   logic [TW-1:0] op_sleep_nxt;
   logic [TW-1:0] op_wake_r;
   logic [TW-1:0] op_wake_nxt;
   logic relay_wait_r;
   logic relay_wait_nxt;
   logic [TW-1:0] relay_cnt_r;
   logic [TW-1:0] relay_cnt_nxt;
   logic req_prev_r;
   logic tmr_load;
   logic [TW-1:0] tmr_val;
   logic tmr_zero;
   logic tick;
   logic wake_start;
   logic awake_n;
   logic [3:0] mode;
   logic sync_mode;
   logic data_rx;
   logic sync_ok;
   rsm_pkg::rsm_sync_t sync_tx_nxt;
   logic relay_nxt;
   logic ind_nxt;
   logic cts_n_nxt;
   logic allow_nxt;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic rsm_pkg::rsm_sync_t make_sync(input logic [TW-1:0] s, input logic [TW-1:0] w);
      rsm_pkg::rsm_sync_t m;
      m.valid = 1'b1;
      m.sleep_period = s;
      m.wake_time = w;
      return m;
   endfunction

   // ==========================================================
   // Timers
   // Divided tick
   rsm_tick #(.W(TW)) u_tick (
      .clk(clk),
      .resetn(resetn),
      .div(div_r),
      .tick(tick)
   );

   rsm_countdown #(.W(TW)) u_tmr (
      .clk(clk),
      .resetn(resetn),
      .tick(tick),
      .load(tmr_load),
      .load_val(tmr_val),
      .zero(tmr_zero)
   );

   // ==========================================================
   // Register file
   // One wait state: the access completes at the second edge it is seen.
   assign wr_en = avs_write && !wait_r;
   assign mode = ctrl_r[rsm_pkg::CTRL_MODE_LSB +: 4];
   assign sync_mode = (mode == rsm_pkg::MODE_SUPPORT) || (mode == rsm_pkg::MODE_SYNC_CYC);
   assign wr_time = wr_en && ((avs_address == rsm_pkg::OFS_SLEEP_PERIOD) || (avs_address == rsm_pkg::OFS_WAKE_TIME));
   assign mode_chg = wr_en && (avs_address == rsm_pkg::OFS_CTRL) && (ctrl_nxt[3:0] != mode);

   always_comb
   begin
      wait_nxt = !wait_r || !(avs_read || avs_write);
      rdata_nxt = avs_readdata;
      ctrl_nxt = ctrl_r;
      sp_nxt = sp_r;
      wt_nxt = wt_r;
      div_nxt = div_r;
      if (avs_read && wait_r)
      begin
         case (avs_address)
            rsm_pkg::OFS_CTRL: rdata_nxt = {25'h0, ctrl_r};
            rsm_pkg::OFS_SLEEP_PERIOD: rdata_nxt = {16'h0, sp_r};
            rsm_pkg::OFS_WAKE_TIME: rdata_nxt = {16'h0, wt_r};
            rsm_pkg::OFS_TICK_DIV: rdata_nxt = {16'h0, div_r};
            rsm_pkg::OFS_STATUS: rdata_nxt = {24'h0, net_wake_r, awake_indicator, coord_r, synced_r, state_r};
            rsm_pkg::OFS_OPER_SLEEP: rdata_nxt = {16'h0, op_sleep_r};
            rsm_pkg::OFS_OPER_WAKE: rdata_nxt = {16'h0, op_wake_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
      if (wr_en)
      begin
         case (avs_address)
            rsm_pkg::OFS_CTRL: ctrl_nxt = CW'(merge({25'h0, ctrl_r}, avs_writedata, avs_byteenable));
            rsm_pkg::OFS_SLEEP_PERIOD: sp_nxt = TW'(merge({16'h0, sp_r}, avs_writedata, avs_byteenable));
            rsm_pkg::OFS_WAKE_TIME: wt_nxt = TW'(merge({16'h0, wt_r}, avs_writedata, avs_byteenable));
            rsm_pkg::OFS_TICK_DIV: div_nxt = TW'(merge({16'h0, div_r}, avs_writedata, avs_byteenable));
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_r <= 1'b1;
         avs_readdata <= 32'h0;
         ctrl_r <= rsm_pkg::CTRL_RST;
         sp_r <= rsm_pkg::SLEEP_RST;
         wt_r <= rsm_pkg::WAKE_RST;
         div_r <= rsm_pkg::TICK_DIV_RST;
      end
      else
      begin
         wait_r <= wait_nxt;
         avs_readdata <= rdata_nxt;
         ctrl_r <= ctrl_nxt;
         sp_r <= sp_nxt;
         wt_r <= wt_nxt;
         div_r <= div_nxt;
      end
   end

   assign avs_waitrequest = wait_r;

   // ==========================================================
   // Sleep sequencer
   assign data_rx = serial_rx_activity || rf_rx_activity;
   assign sync_ok = sync_in.valid && (state_r != rsm_pkg::ST_SLEEP);

   always_comb
   begin
      state_nxt = state_r;
      synced_nxt = synced_r;
      coord_nxt = coord_r;
      net_wake_nxt = net_wake_r;
      op_sleep_nxt = op_sleep_r;
      op_wake_nxt = op_wake_r;
      relay_wait_nxt = relay_wait_r;
      relay_cnt_nxt = relay_cnt_r;
      tmr_load = 1'b0;
      tmr_val = '0;
      wake_start = 1'b0;
      sync_tx_nxt = sync_tx;
      sync_tx_nxt.valid = 1'b0;
      relay_nxt = 1'b0;
      if (!synced_r)
      begin
         op_sleep_nxt = sp_r;
         op_wake_nxt = wt_r;
      end
      if (sync_ok && (sync_mode || mode == rsm_pkg::MODE_NORMAL))
      begin
         synced_nxt = 1'b1;
         relay_nxt = !coord_r;
         op_sleep_nxt = sync_in.sleep_period;
         op_wake_nxt = sync_in.wake_time;
         relay_wait_nxt = 1'b0;
         if (!ctrl_r[rsm_pkg::CTRL_PREF_BIT])
         begin
            coord_nxt = 1'b0;
         end
         if (sync_mode && (state_r != rsm_pkg::ST_DRAIN))
         begin
            net_wake_nxt = 1'b1;
            tmr_load = 1'b1;
            tmr_val = sync_in.wake_time;
         end
      end
      // Local change wins over a received sync
      if (wr_time && sync_mode)
      begin
         op_sleep_nxt = sp_nxt;
         op_wake_nxt = wt_nxt;
         coord_nxt = 1'b1;
      end
      if (sync_join_req && synced_r && mode == rsm_pkg::MODE_SUPPORT)
      begin
         sync_tx_nxt = make_sync(op_sleep_r, op_wake_r);
      end
      case (state_r)
         rsm_pkg::ST_AWAKE:
         begin
            case (mode)
               rsm_pkg::MODE_PIN:
               begin
                  if (sleep_request_input)
                  begin
                     state_nxt = rsm_pkg::ST_DRAIN;
                  end
               end
               rsm_pkg::MODE_CYC, rsm_pkg::MODE_CYC_PIN:
               begin
                  state_nxt = rsm_pkg::ST_SLEEP;
                  tmr_load = 1'b1;
                  tmr_val = sp_r;
               end
               rsm_pkg::MODE_SYNC_CYC:
               begin
                  state_nxt = rsm_pkg::ST_WAKE;
                  tmr_load = 1'b1;
                  tmr_val = op_wake_nxt;
                  wake_start = 1'b1;
               end
               rsm_pkg::MODE_SUPPORT:
               begin
                  if (tmr_zero && !tmr_load)
                  begin
                     net_wake_nxt = !net_wake_r;
                     tmr_load = 1'b1;
                     tmr_val = net_wake_r ? op_sleep_r : op_wake_r;
                     wake_start = !net_wake_r;
                  end
               end
               default: state_nxt = rsm_pkg::ST_AWAKE;
            endcase
         end
         rsm_pkg::ST_DRAIN:
         begin
            if (!sleep_request_input)
            begin
               state_nxt = rsm_pkg::ST_AWAKE;
            end
            else if (!radio_busy)
            begin
               state_nxt = rsm_pkg::ST_SLEEP;
            end
         end
         rsm_pkg::ST_SLEEP:
         begin
            if (mode == rsm_pkg::MODE_PIN)
            begin
               if (!sleep_request_input)
               begin
                  state_nxt = rsm_pkg::ST_AWAKE;
               end
            end
            else if (tmr_zero || (mode == rsm_pkg::MODE_CYC_PIN && req_prev_r && !sleep_request_input))
            begin
               state_nxt = rsm_pkg::ST_WAKE;
               tmr_load = 1'b1;
               // Brief poll window, extended only by data; mode 8 loads its wake time
               tmr_val = (mode == rsm_pkg::MODE_SYNC_CYC) ? op_wake_nxt : '0;
               wake_start = (mode == rsm_pkg::MODE_SYNC_CYC);
            end
         end
         rsm_pkg::ST_WAKE:
         begin
            if (mode == rsm_pkg::MODE_SYNC_CYC)
            begin
               if (tmr_zero && !tmr_load)
               begin
                  state_nxt = rsm_pkg::ST_SLEEP;
                  tmr_load = 1'b1;
                  tmr_val = op_sleep_nxt;
               end
            end
            else if (data_rx)
            begin
               tmr_load = 1'b1;
               tmr_val = wt_r;
            end
            else if (tmr_zero)
            begin
               state_nxt = rsm_pkg::ST_SLEEP;
               tmr_load = 1'b1;
               tmr_val = sp_r;
            end
         end
         default: state_nxt = rsm_pkg::ST_AWAKE;
      endcase
      // One sync at each wake start
      if (wake_start && (coord_nxt || ctrl_r[rsm_pkg::CTRL_PREF_BIT]))
      begin
         sync_tx_nxt = make_sync(op_sleep_nxt, op_wake_nxt);
         synced_nxt = 1'b1;
         relay_wait_nxt = 1'b1;
         relay_cnt_nxt = rsm_pkg::RELAY_WAIT_TICKS;
      end
      // Single resend when no relay heard
      else if (relay_wait_r)
      begin
         if (relay_heard)
         begin
            relay_wait_nxt = 1'b0;
         end
         else if (relay_cnt_r == '0)
         begin
            relay_wait_nxt = 1'b0;
            sync_tx_nxt = make_sync(op_sleep_r, op_wake_r);
         end
         else if (tick)
         begin
            relay_cnt_nxt = relay_cnt_r - 1'b1;
         end
      end
      if (!sync_mode)
      begin
         coord_nxt = 1'b0;
         relay_wait_nxt = 1'b0;
         net_wake_nxt = 1'b0;
      end
      if (mode_chg)
      begin
         state_nxt = rsm_pkg::ST_AWAKE;
      end
   end

   // ==========================================================
   // Output decode
   assign awake_n = (state_nxt != rsm_pkg::ST_SLEEP);

   always_comb
   begin
      ind_nxt = awake_n && (mode == rsm_pkg::MODE_CYC || mode == rsm_pkg::MODE_CYC_PIN
         || ctrl_r[rsm_pkg::CTRL_IND_BIT]);
      cts_n_nxt = ctrl_r[rsm_pkg::CTRL_FLOW_BIT] ? !(awake_n && state_nxt != rsm_pkg::ST_DRAIN) : 1'b0;
      allow_nxt = awake_n;
      if (mode == rsm_pkg::MODE_SUPPORT && synced_nxt)
      begin
         allow_nxt = net_wake_nxt;
      end
      else if (mode == rsm_pkg::MODE_SYNC_CYC)
      begin
         allow_nxt = (state_nxt == rsm_pkg::ST_WAKE);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= rsm_pkg::ST_AWAKE;
         synced_r <= 1'b0;
         coord_r <= 1'b0;
         net_wake_r <= 1'b0;
         op_sleep_r <= rsm_pkg::SLEEP_RST;
         op_wake_r <= rsm_pkg::WAKE_RST;
         relay_wait_r <= 1'b0;
         relay_cnt_r <= '0;
         req_prev_r <= 1'b0;
         sync_tx <= '0;
         sync_relay <= 1'b0;
         awake_indicator <= 1'b0;
         cts_n <= 1'b0;
         radio_on <= 1'b1;
         serial_accept <= 1'b1;
         data_tx_allow <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         synced_r <= synced_nxt;
         coord_r <= coord_nxt;
         net_wake_r <= net_wake_nxt;
         op_sleep_r <= op_sleep_nxt;
         op_wake_r <= op_wake_nxt;
         relay_wait_r <= relay_wait_nxt;
         relay_cnt_r <= relay_cnt_nxt;
         req_prev_r <= sleep_request_input;
         sync_tx <= sync_tx_nxt;
         sync_relay <= relay_nxt;
         awake_indicator <= ind_nxt;
         cts_n <= cts_n_nxt;
         radio_on <= awake_n;
         serial_accept <= awake_n;
         data_tx_allow <= allow_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- tb/rsm_props.sv ----
// Checker for the sleep mode controller ports.
`timescale 1ns/1ps
`default_nettype none
module rsm_props (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // Pins
   input wire logic radio_busy,
   input wire rsm_pkg::rsm_sync_t sync_in,
   input wire logic awake_indicator,
   input wire logic radio_on,
   input wire logic serial_accept,
   input wire logic data_tx_allow,
   input wire rsm_pkg::rsm_sync_t sync_tx,
   input wire logic sync_relay
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Bus handshake
   property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("waitrequest did not answer");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_wait_idle; !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");
   // ==========================================================
   // Sleep behaviour
   property p_relay; sync_relay |-> $past(sync_in.valid); endproperty
   a_relay: assert property (p_relay) else $error("relay without received sync");
   property p_sync_one; sync_tx.valid |=> !sync_tx.valid; endproperty
   a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
   property p_ind; awake_indicator |-> radio_on; endproperty
   a_ind: assert property (p_ind) else $error("indicator high while asleep");
   property p_noser; !radio_on |-> !serial_accept && !data_tx_allow; endproperty
   a_noser: assert property (p_noser) else $error("input accepted while asleep");
   property p_busy; $fell(radio_on) |-> !$past(radio_busy); endproperty
   a_busy: assert property (p_busy) else $error("slept during activity");
endmodule
bind rsm_ctrl rsm_props u_rsm_props (.clk(clk), .resetn(resetn), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .radio_busy(radio_busy),
   .sync_in(sync_in), .awake_indicator(awake_indicator), .radio_on(radio_on),
   .serial_accept(serial_accept), .data_tx_allow(data_tx_allow), .sync_tx(sync_tx),
   .sync_relay(sync_relay));
`default_nettype wire

// ---- tb/rsm_host_model.sv ----
// Host model driving the sleep request and serial activity pins.
`timescale 1ns/1ps
`default_nettype none
module rsm_host_model (
   // Clock
   input wire logic clk,
   // Host pins
   output var logic sleep_request_input,
   output var logic serial_rx_activity
);
   initial
   begin
      sleep_request_input = 1'b0;
      serial_rx_activity = 1'b0;
   end
   // Levels change only just after an edge, like a synchronous host.
   task automatic set_req(input logic v);
      sleep_request_input <= v;
   endtask
   task automatic set_rx(input logic v);
      serial_rx_activity <= v;
   endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench of the sleep mode controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, radio_busy = 1'b0, join_req = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic [3:0] be = 4'hf;
   logic rfx = 1'b0, hrd = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, sreq, srx, ind, cts_n, radio_on, ser_ok, tx_ok, relay;
   rsm_pkg::rsm_sync_t sync_in = '0, sync_tx;
   int err_count = 0, n_checks = 0, cyc = 0, n;
   always #4 clk = ~clk;
   rsm_host_model u_rsm_host_model (.clk(clk), .sleep_request_input(sreq), .serial_rx_activity(srx));
   rsm_ctrl u_rsm_ctrl (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(be), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_request_input(sreq),
      .serial_rx_activity(srx), .rf_rx_activity(rfx), .radio_busy(radio_busy), .sync_in(sync_in),
      .sync_join_req(join_req), .relay_heard(hrd), .awake_indicator(ind), .cts_n(cts_n),
      .radio_on(radio_on), .serial_accept(ser_ok), .data_tx_allow(tx_ok), .sync_tx(sync_tx),
      .sync_relay(relay));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_count++;
         complete_run();
      end
   end
   task automatic cmp(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   // One Avalon access; waitrequest and read data are taken at the same edge.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_on(input logic v);
      n = 0;
      while (radio_on !== v && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      cmp("wait", n < 3000, 1);
   endtask
   task automatic count_sync(input int k);
      n = 0;
      repeat (k)
      begin
         @(posedge clk);
         n += int'(sync_tx.valid);
         hrd <= 1'b0;
      end
   endtask
   task automatic setup(input logic [31:0] sp, input logic [31:0] wt, input logic [31:0] ctrl);
      bus(1, rsm_pkg::OFS_TICK_DIV, 32'h0);
      bus(1, rsm_pkg::OFS_SLEEP_PERIOD, sp);
      bus(1, rsm_pkg::OFS_WAKE_TIME, wt);
      bus(1, rsm_pkg::OFS_CTRL, ctrl);
   endtask
   task automatic t_reset();
      bus(0, rsm_pkg::OFS_CTRL, 0); cmp("ctrl", q, 32'(rsm_pkg::CTRL_RST));
      bus(0, rsm_pkg::OFS_SLEEP_PERIOD, 0); cmp("sp", q, 32'(rsm_pkg::SLEEP_RST));
      bus(0, rsm_pkg::OFS_WAKE_TIME, 0); cmp("wt", q, 32'(rsm_pkg::WAKE_RST));
      bus(0, rsm_pkg::OFS_TICK_DIV, 0); cmp("div", q, 32'(rsm_pkg::TICK_DIV_RST));
      bus(1, 5'h1c, 32'hffff_ffff);
      bus(0, 5'h1c, 0); cmp("unmapped", q, 32'h0);
      be <= 4'h2;
      bus(1, rsm_pkg::OFS_SLEEP_PERIOD, 32'hffff_ab00);
      be <= 4'hf;
      bus(0, rsm_pkg::OFS_SLEEP_PERIOD, 0); cmp("lanes", q, 32'h0000_ab64);
      $display("test reset done");
   endtask
   task automatic t_mode0();
      sync_in <= '{1'b1, 16'h0010, 16'h0004};
      @(posedge clk);
      sync_in <= '0;
      n = 0;
      repeat (40)
      begin
         @(posedge clk);
         n += int'(relay);
         cmp("awake", {radio_on, tx_ok, sync_tx.valid}, 32'h6);
      end
      cmp("relayed", n, 1);
      $display("test mode0 done");
   endtask
   task automatic t_mode1();
      bus(1, rsm_pkg::OFS_CTRL, 32'h11);
      radio_busy <= 1'b1;
      u_rsm_host_model.set_req(1'b1);
      repeat (4) @(posedge clk);
      cmp("drain", {radio_on, cts_n}, 32'h3);
      radio_busy <= 1'b0;
      wait_on(0);
      cmp("sleep", {n <= 3, ser_ok, cts_n}, 32'h5);
      u_rsm_host_model.set_req(1'b0);
      wait_on(1);
      @(posedge clk);
      cmp("wake", {n <= 3, cts_n}, 32'h2);
      $display("test mode1 done");
   endtask
   task automatic t_mode4();
      setup(8, 3, 32'h04);
      wait_on(0);
      cmp("asleep", {ind, cts_n}, 32'h0);
      wait_on(1);
      cmp("period", {n >= 6, n <= 12, ind}, 32'h7);
      wait_on(0);
      cmp("poll", n <= 3, 1);
      u_rsm_host_model.set_rx(1'b1);
      wait_on(1);
      rfx <= 1'b1;
      u_rsm_host_model.set_rx(1'b0);
      repeat (10) @(posedge clk);
      cmp("extend", radio_on, 1);
      rfx <= 1'b0;
      wait_on(0);
      cmp("expire", {n >= 2, n <= 7}, 32'h3);
      $display("test mode4 done");
   endtask
   task automatic t_mode5();
      setup(32'h200, 3, 32'h05);
      wait_on(0);
      u_rsm_host_model.set_req(1'b1);
      repeat (5) @(posedge clk);
      cmp("held", radio_on, 0);
      u_rsm_host_model.set_req(1'b0);
      wait_on(1);
      cmp("early", n <= 4, 1);
      $display("test mode5 done");
   endtask
   task automatic t_mode7();
      bus(1, rsm_pkg::OFS_CTRL, 32'h07);
      join_req <= 1'b1;
      @(posedge clk);
      join_req <= 1'b0;
      n = 0;
      repeat (200)
      begin
         @(posedge clk);
         n += int'(sync_tx.valid);
         cmp("support", radio_on, 1);
      end
      cmp("answer", n >= 1, 1);
      $display("test mode7 done");
   endtask
   task automatic t_mode8();
      setup(8, 3, 32'h28);
      count_sync(8);
      cmp("resend", n, 2);
      wait_on(0);
      cmp("ignored", {ser_ok, ind}, 32'h0);
      wait_on(1);
      cmp("ind", ind, 1);
      hrd <= 1'b1;
      count_sync(8);
      cmp("heard", n, 0);
      wait_on(0);
      wait_on(1);
      cmp("relisten", n <= 12, 1);
      wait_on(0);
      sync_in <= '{1'b1, 16'h0006, 16'h0002};
      wait_on(1);
      sync_in <= '0;
      bus(0, rsm_pkg::OFS_OPER_SLEEP, 0); cmp("oper_sp", q, 32'h6);
      bus(0, rsm_pkg::OFS_OPER_WAKE, 0); cmp("oper_wt", q, 32'h2);
      bus(0, rsm_pkg::OFS_STATUS, 0); cmp("synced", q[4], 1);
      $display("test mode8 done");
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_mode0();
      t_mode1();
      t_mode4();
      t_mode5();
      t_mode7();
      t_mode8();
      complete_run();
   end
endmodule
`default_nettype wire
